// File: core/slc_pkg.sv
// package: register map, field layout and code tables of the serial channel line configuration
package slc_pkg;

    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [3:0] SLC_OFF_CTRL = 4'h0;
    localparam logic [3:0] SLC_OFF_SYNC = 4'h4;
    localparam logic [3:0] SLC_OFF_STAT = 4'h8;

    localparam int SLC_CTRL_W = 25;
    localparam logic [24:0] SLC_CTRL_RST = 25'h0000000;
    // sync pattern resets to two flag bytes
    localparam logic [15:0] SLC_SYNC_RST = 16'h7E7E;

    // ==========================================================
    // code values
    localparam logic [1:0] SLC_SYNC_LENGTH_SEL_EXT = 2'h0;
    localparam logic [1:0] SLC_SYNC_LENGTH_SEL_4 = 2'h1;
    localparam logic [1:0] SLC_SYNC_LENGTH_SEL_8 = 2'h2;
    localparam logic [1:0] SLC_RATE_X1 = 2'h0;
    localparam logic [1:0] SLC_EDGE_BOTH = 2'h0;
    localparam logic [1:0] SLC_EDGE_RISE = 2'h1;
    localparam logic [1:0] SLC_EDGE_FALL = 2'h2;
    localparam logic [1:0] SLC_CSH_INF = 2'h0;
    localparam logic [3:0] SLC_RX_ALIGN_BITS = 4'h8;

    // ==========================================================
    // control word layout, msb first
    typedef struct packed {
        logic async_mode;
        logic [1:0] rx_pll_rate;
        logic [1:0] tx_divide_rate;
        logic idle_encode;
        logic [1:0] preamble_pattern_sel;
        logic [2:0] preamble_length_sel;
        logic tx_data_invert;
        logic rx_data_invert;
        logic [1:0] carrier_sense_hold;
        logic tx_clock_invert;
        logic [1:0] dpll_edge_sel;
        logic carrier_detect_sample_sync;
        logic rts_between_frames_mode;
        logic [1:0] sync_length_sel;
        logic rx_sync_timing;
        logic tx_sync_to_rx;
        logic enable;
    } slc_cfg_s;

    // status word, low bits
    typedef struct packed {
        logic cts_active;
        logic cd_active;
        logic tx_busy;
        logic carrier_sense;
        logic rx_synced;
    } slc_stat_s;

    typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_PRE, TX_SYNC, TX_DATA} slc_tx_e;

    // serial clock periods per bit for a divide code
    function automatic logic [5:0] slc_rate(input logic [1:0] code);
        case (code)
            2'h0: slc_rate = 6'h01;
            2'h1: slc_rate = 6'h08;
            2'h2: slc_rate = 6'h10;
            default: slc_rate = 6'h20;
        endcase
    endfunction

    // preamble bits for a length code; reserved code sends none
    function automatic logic [7:0] slc_pre_bits(input logic [2:0] code);
        case (code)
            3'h1: slc_pre_bits = 8'h08;
            3'h2: slc_pre_bits = 8'h10;
            3'h3: slc_pre_bits = 8'h20;
            3'h4: slc_pre_bits = 8'h30;
            3'h5: slc_pre_bits = 8'h40;
            3'h6: slc_pre_bits = 8'h80;
            default: slc_pre_bits = 8'h00;
        endcase
    endfunction

    // carrier sense hold in half bit times: larger figure for x1, smaller otherwise
    function automatic logic [4:0] slc_cs_half(input logic [1:0] code, input logic x1);
        case (code)
            2'h1: slc_cs_half = x1 ? 5'h1C : 5'h0D;
            2'h2: slc_cs_half = x1 ? 5'h08 : 5'h03;
            default: slc_cs_half = x1 ? 5'h06 : 5'h02;
        endcase
    endfunction

endpackage

// File: core/slc_line_cfg.sv
// serial channel line configuration: register slave, tx sequencer, rx dpll and carrier sense
`timescale 1ns/100ps
// ==========================================================
module slc_line_cfg
    import slc_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // serial line pins
    input wire logic i_ser_clk,
    input wire logic i_rxd,
    input wire logic i_cd_n,
    input wire logic i_cts_n,
    output logic o_txd,
    output logic o_rts_n,
    // protocol side
    input wire logic i_tx_frame_valid,
    input wire logic i_tx_data,
    output logic o_tx_take,
    output logic o_rx_bit,
    output logic o_rx_bit_valid,
    output logic o_rx_synced,
    output logic o_carrier_sense
);

    // ==========================================================
    // registers and bus slave
    slc_cfg_s cfg;
    logic [15:0] sync_pat;
    logic [31:0] ctrl_word;
    logic [31:0] sync_word;
    logic [31:0] stat_word;
    logic [31:0] wmask;
    logic bus_req;
    slc_stat_s stat;

    assign bus_req = i_avs_read | i_avs_write;
    assign ctrl_word = {7'h00, cfg};
    assign sync_word = {16'h0000, sync_pat};
    assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // one wait cycle then a one-cycle answer; write lands on the answering edge
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h00000000;
        end else if (i_ce) begin
            o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest) begin
                case (i_avs_address)
                    SLC_OFF_CTRL: o_avs_readdata <= ctrl_word;
                    SLC_OFF_SYNC: o_avs_readdata <= sync_word;
                    SLC_OFF_STAT: o_avs_readdata <= stat_word;
                    default: o_avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cfg <= slc_cfg_s'(SLC_CTRL_RST);
            sync_pat <= SLC_SYNC_RST;
        end else if (i_ce && i_avs_write && !o_avs_waitrequest) begin
            if (i_avs_address == SLC_OFF_CTRL) begin
                cfg <= slc_cfg_s'(25'((ctrl_word & ~wmask) | (i_avs_writedata & wmask)));
            end
            if (i_avs_address == SLC_OFF_SYNC) begin
                sync_pat <= 16'((sync_word & ~wmask) | (i_avs_writedata & wmask));
            end
        end
    end

    // ==========================================================
    // pin synchronisers; first stage feeds only the second
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic sclk_d;
    logic rxd_d;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            // serial clock idles low, so no false edge follows reset
            pin_s1 <= 4'h7;
            pin_s2 <= 4'h7;
            sclk_d <= 1'b0;
            rxd_d <= 1'b1;
        end else if (i_ce) begin
            pin_s1 <= {i_ser_clk, i_rxd, i_cd_n, i_cts_n};
            pin_s2 <= pin_s1;
            sclk_d <= pin_s2[3];
            rxd_d <= pin_s2[2] ^ cfg.rx_data_invert;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic rx_dat;
    logic cd_on;
    logic cts_on;
    assign sclk_rise = pin_s2[3] && !sclk_d;
    assign sclk_fall = !pin_s2[3] && sclk_d;
    assign rx_dat = pin_s2[2] ^ cfg.rx_data_invert;
    assign cd_on = !pin_s2[1];
    assign cts_on = !pin_s2[0];

    // ==========================================================
    // receive dpll: sample point re-centred on selected data edges
    logic [5:0] rx_rate;
    logic [5:0] rx_phase;
    logic rx_x1;
    logic adj_ok;
    logic data_rise;
    logic data_fall;
    logic adj_evt;
    logic adj_pend;
    logic rx_sample;

    assign rx_rate = slc_rate(cfg.rx_pll_rate);
    assign rx_x1 = (cfg.rx_pll_rate == SLC_RATE_X1);
    assign adj_ok = !cfg.async_mode && !rx_x1;
    assign data_rise = rx_dat && !rxd_d;
    assign data_fall = !rx_dat && rxd_d;
    always_comb begin
        case (cfg.dpll_edge_sel)
            SLC_EDGE_BOTH: adj_evt = data_rise || data_fall;
            SLC_EDGE_RISE: adj_evt = data_rise;
            SLC_EDGE_FALL: adj_evt = data_fall;
            default: adj_evt = 1'b0;
        endcase
    end
    assign rx_sample = sclk_rise && (rx_phase == (rx_rate >> 1));

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_phase <= 6'h00;
            adj_pend <= 1'b0;
        end else if (i_ce) begin
            if (sclk_rise) begin
                if (adj_pend && adj_ok) begin
                    rx_phase <= 6'h00;
                end else if (rx_phase >= rx_rate - 6'h01) begin
                    rx_phase <= 6'h00;
                end else begin
                    rx_phase <= rx_phase + 6'h01;
                end
            end
            // a new edge wins over the consume
            if (adj_evt) begin
                adj_pend <= 1'b1;
            end else if (sclk_rise) begin
                adj_pend <= 1'b0;
            end
        end
    end

    // ==========================================================
    // receive sync hunt and bit output
    logic [15:0] rx_shift;
    logic [15:0] next_shift;
    logic [15:0] sync_mask;
    logic rx_synced;
    logic [3:0] rx_bits;
    logic cd_d;

    assign next_shift = {rx_dat, rx_shift[15:1]};
    // newest bits sit at the top of the shifter, so match the top n pattern bits
    always_comb begin
        case (cfg.sync_length_sel)
            SLC_SYNC_LENGTH_SEL_4: sync_mask = 16'hF000;
            SLC_SYNC_LENGTH_SEL_8: sync_mask = 16'hFF00;
            default: sync_mask = 16'hFFFF;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rx_shift <= 16'h0000;
            rx_synced <= 1'b0;
            rx_bits <= 4'h0;
            cd_d <= 1'b0;
            o_rx_bit <= 1'b0;
            o_rx_bit_valid <= 1'b0;
            o_rx_synced <= 1'b0;
        end else if (i_ce) begin
            cd_d <= cd_on;
            o_rx_bit_valid <= rx_sample && rx_synced;
            o_rx_synced <= rx_synced;
            if (rx_sample) begin
                rx_shift <= next_shift;
                o_rx_bit <= rx_dat;
            end
            if (!cfg.enable) begin
                rx_synced <= 1'b0;
                rx_bits <= 4'h0;
            end else if (cfg.sync_length_sel == SLC_SYNC_LENGTH_SEL_EXT) begin
                rx_synced <= cd_on;
                if (cd_on && !cd_d) begin
                    // remote raises carrier on the second bit, so one bit is already in
                    rx_bits <= (cfg.rx_sync_timing && cfg.carrier_detect_sample_sync)
                               ? 4'h1 : 4'h0;
                end else if (rx_sample && rx_bits != SLC_RX_ALIGN_BITS) begin
                    rx_bits <= rx_bits + 4'h1;
                end
            end else if (!rx_synced) begin
                if (rx_sample && ((next_shift & sync_mask) == (sync_pat & sync_mask))) begin
                    rx_synced <= 1'b1;
                    rx_bits <= 4'h0;
                end
            end else if (rx_sample && rx_bits != SLC_RX_ALIGN_BITS) begin
                rx_bits <= rx_bits + 4'h1;
            end
        end
    end

    // ==========================================================
    // carrier sense: counted in serial clock half periods since last transition
    logic [9:0] cs_cnt;
    logic [9:0] cs_limit;
    logic cs_active;

    assign cs_limit = 10'(slc_cs_half(cfg.carrier_sense_hold, rx_x1) * rx_rate);
    assign cs_active = (cfg.carrier_sense_hold == SLC_CSH_INF) || (cs_cnt < cs_limit);

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cs_cnt <= 10'h3FF;
            o_carrier_sense <= 1'b1;
        end else if (i_ce) begin
            if (data_rise || data_fall) begin
                cs_cnt <= 10'h000;
            end else if ((sclk_rise || sclk_fall) && cs_cnt != 10'h3FF) begin
                cs_cnt <= cs_cnt + 10'h001;
            end
            o_carrier_sense <= cs_active;
        end
    end

    // ==========================================================
    // transmit sequencer
    slc_tx_e tx_st;
    logic [5:0] tx_rate;
    logic [5:0] tx_cnt;
    logic tx_edge;
    logic tx_tick;
    logic [7:0] tx_bitn;
    logic [3:0] idle_idx;
    logic [7:0] pre_len;
    logic pre_bit;
    logic align_ok;
    logic start_ok;

    assign tx_rate = slc_rate(cfg.tx_divide_rate);
    assign tx_edge = cfg.tx_clock_invert ? sclk_rise : sclk_fall;
    assign tx_tick = tx_edge && (tx_cnt >= tx_rate - 6'h01);
    assign pre_len = cfg.async_mode ? 8'h00 : slc_pre_bits(cfg.preamble_length_sel);
    always_comb begin
        case (cfg.preamble_pattern_sel)
            2'h0: pre_bit = 1'b0;
            2'h1: pre_bit = !tx_bitn[0];
            2'h2: pre_bit = tx_bitn[0];
            default: pre_bit = 1'b1;
        endcase
    end
    always_comb begin
        if (!cfg.tx_sync_to_rx) begin
            align_ok = 1'b1;
        end else if (cfg.rx_sync_timing) begin
            align_ok = rx_synced && cts_on && (rx_bits == SLC_RX_ALIGN_BITS);
        end else begin
            align_ok = rx_synced && (rx_bits[2:0] == 3'h0);
        end
    end
    assign start_ok = cts_on && align_ok;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_cnt <= 6'h00;
        end else if (i_ce && tx_edge) begin
            tx_cnt <= tx_tick ? 6'h00 : tx_cnt + 6'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_st <= TX_IDLE;
            tx_bitn <= 8'h00;
            idle_idx <= 4'h0;
            o_txd <= 1'b1;
            o_tx_take <= 1'b0;
        end else if (i_ce) begin
            o_tx_take <= 1'b0;
            if (!cfg.enable) begin
                tx_st <= TX_IDLE;
                o_txd <= 1'b1;
            end else if (tx_tick) begin
                tx_bitn <= tx_bitn + 8'h01;
                case (tx_st)
                    TX_IDLE, TX_WAIT: begin
                        if (cfg.rts_between_frames_mode) begin
                            o_txd <= sync_pat[idle_idx] ^ cfg.tx_data_invert;
                            idle_idx <= idle_idx + 4'h1;
                        end else begin
                            // unencoded idle is a plain high line
                            o_txd <= cfg.idle_encode ? !cfg.tx_data_invert : 1'b1;
                        end
                        if (tx_st == TX_IDLE && i_tx_frame_valid) begin
                            tx_st <= TX_WAIT;
                        end else if (tx_st == TX_WAIT && start_ok) begin
                            tx_bitn <= 8'h00;
                            if (pre_len != 8'h00) begin
                                tx_st <= TX_PRE;
                            end else if (cfg.sync_length_sel != SLC_SYNC_LENGTH_SEL_EXT) begin
                                tx_st <= TX_SYNC;
                            end else begin
                                tx_st <= TX_DATA;
                            end
                        end
                    end
                    TX_PRE: begin
                        o_txd <= pre_bit ^ cfg.tx_data_invert;
                        if (tx_bitn == pre_len - 8'h01) begin
                            tx_bitn <= 8'h00;
                            tx_st <= (cfg.sync_length_sel != SLC_SYNC_LENGTH_SEL_EXT) ? TX_SYNC : TX_DATA;
                        end
                    end
                    TX_SYNC: begin
                        // whole pattern, lsb first
                        o_txd <= sync_pat[tx_bitn[3:0]] ^ cfg.tx_data_invert;
                        if (tx_bitn == 8'h0F) begin
                            tx_st <= TX_DATA;
                        end
                    end
                    TX_DATA: begin
                        if (i_tx_frame_valid) begin
                            o_txd <= i_tx_data ^ cfg.tx_data_invert;
                            o_tx_take <= 1'b1;
                        end else begin
                            tx_st <= TX_IDLE;
                            idle_idx <= 4'h0;
                            o_txd <= (cfg.idle_encode || cfg.rts_between_frames_mode)
                                     ? !cfg.tx_data_invert : 1'b1;
                        end
                    end
                    default: tx_st <= TX_IDLE;
                endcase
            end
        end
    end

    // rts: held while enabled in mode 1, only around frames in mode 0
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rts_n <= 1'b1;
        end else if (i_ce) begin
            if (cfg.rts_between_frames_mode) begin
                o_rts_n <= !cfg.enable;
            end else begin
                o_rts_n <= !(cfg.enable && tx_st != TX_IDLE);
            end
        end
    end

    assign stat = '{cts_active: cts_on, cd_active: cd_on, tx_busy: (tx_st != TX_IDLE),
                    carrier_sense: o_carrier_sense, rx_synced: rx_synced};
    assign stat_word = {27'h0000000, stat};

    // ==========================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_bus_wait;
        bus_req && o_avs_waitrequest && i_ce;
    endsequence
    sequence s_bus_ans;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence
    property p_bus_answer;
        s_bus_wait |=> s_bus_ans;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

    property p_rts_mode1;
        i_ce && cfg.rts_between_frames_mode && cfg.enable |=> !o_rts_n;
    endproperty
    a_rts_mode1: assert property (p_rts_mode1) else $error("rts dropped in mode 1");

    property p_rts_mode0;
        i_ce && !cfg.rts_between_frames_mode && tx_st == TX_IDLE |=> o_rts_n;
    endproperty
    a_rts_mode0: assert property (p_rts_mode0) else $error("rts held between frames");

    property p_ext_sync;
        i_ce && cfg.enable && cfg.sync_length_sel == SLC_SYNC_LENGTH_SEL_EXT |=> rx_synced == $past(cd_on);
    endproperty
    a_ext_sync: assert property (p_ext_sync) else $error("sync not from carrier detect");

    property p_cs_inf;
        i_ce && cfg.carrier_sense_hold == SLC_CSH_INF |=> o_carrier_sense;
    endproperty
    a_cs_inf: assert property (p_cs_inf) else $error("carrier sense dropped");

    property p_no_adjust;
        i_ce && sclk_rise && !adj_ok && rx_phase < rx_rate - 6'h01 |=> rx_phase == $past(rx_phase) + 6'h01;
    endproperty
    a_no_adjust: assert property (p_no_adjust) else $error("sample point moved");

    property p_idle_high;
        i_ce && cfg.enable && tx_tick && tx_st == TX_IDLE && !cfg.rts_between_frames_mode
            && !cfg.idle_encode |=> o_txd;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line not high");

    property p_align;
        i_ce && tx_tick && cfg.enable && tx_st == TX_WAIT && cfg.tx_sync_to_rx && cfg.rx_sync_timing
            ##1 tx_st != TX_WAIT |-> $past(rx_bits) == SLC_RX_ALIGN_BITS && $past(cts_on);
    endproperty
    a_align: assert property (p_align) else $error("tx start not aligned");

    property p_sync_len;
        i_ce && cfg.enable && tx_tick && tx_st == TX_SYNC && tx_bitn == 8'h0F |=> tx_st == TX_DATA;
    endproperty
    a_sync_len: assert property (p_sync_len) else $error("sync pattern length wrong");

endmodule // slc_line_cfg

// File: verif/slc_remote_model.sv
// remote station model: serial clock, receive data and modem lines
`timescale 1ns/100ps
module slc_remote_model (
    // control from the bench
    input wire logic i_run,
    input wire logic i_cd_late,
    // serial line toward the channel
    output logic o_ser_clk,
    output logic o_rxd,
    output logic o_cd_n,
    output logic o_cts_n
);
    // ==========================================================
    // frame generator
    int bits;
    initial begin
        o_ser_clk = 1'b0;
        o_rxd = 1'b1;
        o_cd_n = 1'b1;
        o_cts_n = 1'b1;
    end
    // clock stands still between frames; 3 ns skew keeps pin edges off i_clk edges
    always begin
        wait (i_run);
        #3;
        bits = 0;
        o_cts_n = 1'b0;
        while (i_run) begin
            #32 o_ser_clk = 1'b1;
            #32 o_ser_clk = 1'b0;
            o_rxd = bits[0] ^ bits[2];
            bits++;
            if (bits == (i_cd_late ? 2 : 1)) o_cd_n = 1'b0;
        end
        o_cd_n = 1'b1;
        o_cts_n = 1'b1;
        o_rxd = 1'b1;
    end
endmodule // slc_remote_model

// File: verif/slc_line_cfg_bench.sv
// self-checking bench for the serial channel line configuration
`timescale 1ns/100ps
module slc_line_cfg_bench;
    import slc_pkg::*;
    // ==========================================================
    // signals
    logic clk = 1'b0, srst = 1'b1, rd = 1'b0, wr = 1'b0, wait_rq, ser_clk, rxd, cd_n, cts_n;
    logic [3:0] adr = 4'h0, be = 4'hF;
    logic [31:0] wd = 32'h0, rdata, q, r;
    logic txd, rts_n, tx_valid = 1'b0, tx_data = 1'b0, take, rx_bit, rx_val, synced, csense;
    logic run = 1'b0, found, seen, late = 1'b0, d_old = 1'b0;
    logic [15:0] sh = 16'h0, sync_exp;
    int err_count = 0, samples_checked = 0, cyc = 0, seed = 32'hf62e, takes = 0;
    slc_line_cfg dut (.i_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq), .i_ser_clk(ser_clk), .i_rxd(rxd),
        .i_cd_n(cd_n), .i_cts_n(cts_n), .o_txd(txd), .o_rts_n(rts_n),
        .i_tx_frame_valid(tx_valid), .i_tx_data(tx_data), .o_tx_take(take), .o_rx_bit(rx_bit),
        .o_rx_bit_valid(rx_val), .o_rx_synced(synced), .o_carrier_sense(csense));
    slc_remote_model remote (.i_run(run), .i_cd_late(late), .o_ser_clk(ser_clk), .o_rxd(rxd),
        .o_cd_n(cd_n), .o_cts_n(cts_n));
    initial begin
        forever #2 clk = ~clk;
    end
    // ==========================================================
    // helpers
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // avalon master: hold request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] m);
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= m;
        do @(posedge clk); while (wait_rq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_sim();
        end
    end
    // sync pattern goes out lsb first, so shift new bits in at the top
    always @(posedge ser_clk) begin
        sh <= {txd, sh[15:1]};
        if ({txd, sh[15:1]} == sync_exp) found = 1'b1;
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        bus(0, SLC_OFF_CTRL, 0, 4'hF); chk(q, {7'h0, SLC_CTRL_RST});
        bus(0, SLC_OFF_SYNC, 0, 4'hF); chk(q, {16'h0, SLC_SYNC_RST});
        bus(0, SLC_OFF_STAT, 0, 4'hF); chk(q, 32'h2);
        bus(1, 4'hC, 32'h1234, 4'hF);
        bus(0, 4'hC, 0, 4'hF); chk(q, 32'h0);
        bus(1, SLC_OFF_SYNC, 32'hFFFF_A5C3, 4'hF);
        bus(1, SLC_OFF_SYNC, 32'h0000_1100, 4'h2);
        bus(0, SLC_OFF_SYNC, 0, 4'hF); chk(q, 32'h11C3);
        sync_exp = 16'h11C3;
        // enable kept clear so odd rate or invert mixes never run on the line
        repeat (8) begin
            r = $random(seed) & 32'hFFFF_FFFE;
            bus(1, SLC_OFF_CTRL, r, 4'hF);
            bus(0, SLC_OFF_CTRL, 0, 4'hF); chk(q, r & 32'h01FF_FFFF);
        end
        $display("register test done");
        // frame 0: 16-bit sync; 1: async x8 with tx sync; 2: tx sync, rx timing, late carrier
        for (int f = 0; f < 3; f++) begin
            bus(1, SLC_OFF_CTRL, (f == 0) ? 32'h19 : (f == 1) ? 32'h0150_0003 : 32'h47, 4'hF);
            repeat (8) @(posedge clk);
            chk({31'h0, txd}, 32'h1);
            chk({31'h0, rts_n}, 32'h1);
            late = (f == 2);
            run = 1'b1;
            found = 1'b0;
            seen = 1'b0;
            takes = 0;
            tx_valid <= 1'b1;
            repeat (1200) begin
                @(posedge clk);
                if (take === 1'b1) chk({31'h0, txd}, {31'h0, d_old});
                if (rx_val === 1'b1) chk({31'h0, rx_bit}, {31'h0, rxd});
                if (take === 1'b1) takes++;
                // the bit taken at an edge was driven one cycle before it
                d_old = tx_data;
                tx_data <= $random(seed);
                if (synced === 1'b1) seen = 1'b1;
            end
            chk({31'h0, f ? seen : found}, 32'h1);
            chk({31'h0, takes != 0}, 32'h1);
            chk({31'h0, csense}, 32'h1);
            tx_valid <= 1'b0;
            repeat (600) @(posedge clk);
            run = 1'b0;
            repeat (40) @(posedge clk);
            chk({31'h0, txd}, 32'h1);
            chk({31'h0, rts_n}, 32'h1);
            $display("frame test %0d done", f);
        end
        bus(1, SLC_OFF_CTRL, 32'h21, 4'hF);
        repeat (8) @(posedge clk);
        chk({31'h0, rts_n}, 32'h0);
        bus(1, SLC_OFF_CTRL, 32'h20, 4'hF);
        repeat (8) @(posedge clk);
        chk({31'h0, rts_n}, 32'h1);
        $display("rts mode test done");
        end_sim();
    end
endmodule // slc_line_cfg_bench
